// ---- touch_i2c_port.sv ----
// I2C target port with message pointer, checksums and pending line.
`timescale 1ns/1ps
module touch_i2c_port #(
  parameter logic [14:0] MSG_ADDR = touch_i2c_pkg::MSG_ADDR_DEF,
  parameter logic [14:0] CNT_ADDR = touch_i2c_pkg::CNT_ADDR_DEF,
  parameter logic [14:0] MSG_LEN  = touch_i2c_pkg::MSG_LEN_DEF,
  parameter logic [7:0]  CRC_POLY = touch_i2c_pkg::CRC_POLY_DEF,
  parameter logic [7:0]  CRC_INIT = touch_i2c_pkg::CRC_INIT_DEF
) (
  input  wire logic                    i_sys_clk,          // 100 MHz
  input  wire logic                    i_rst_n,            // Async reset
  input  wire logic                    i_scl,              // SCL level
  input  wire logic                    i_sda,              // SDA level
  input  wire logic                    i_addr_select_pin,  // Address strap
  input  wire touch_i2c_pkg::chg_cfg_s i_comms_cfg,        // Line config
  input  wire logic [7:0]              i_msg_count,        // Pending msgs
  input  wire logic [7:0]              i_mem_rdata,        // Read data
  output logic                         o_scl_o,            // SCL drive value
  output logic                         o_scl_oe,           // SCL drive en
  output logic                         o_sda_o,            // SDA drive value
  output logic                         o_sda_oe,           // SDA drive en
  output logic                         o_msg_pending_n_o,  // Line value
  output logic                         o_msg_pending_n_oe, // Line pull low
  output logic [14:0]                  o_mem_raddr,        // Read address
  output touch_i2c_pkg::mem_req_s      o_mem,              // Write request
  output logic                         o_msg_pop,          // Msg consumed
  output logic                         o_comms_crc_fault   // Bad write CRC
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // Pin synchronisers; the third stage only feeds edge detection.
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic sel_s1_q, sel_s2_q;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      {sel_s1_q, sel_s2_q}           <= 2'h0;
    end else begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {i_scl, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {i_sda, sda_s1_q, sda_s2_q};
      {sel_s1_q, sel_s2_q}           <= {i_addr_select_pin, sel_s1_q};
    end
  end

  logic scl_rise_c, scl_fall_c, start_c, stop_c;
  assign scl_rise_c = scl_s2_q & ~scl_s3_q;
  assign scl_fall_c = ~scl_s2_q & scl_s3_q;
  assign start_c    = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign stop_c     = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

  // The strap is caught once, after the synchroniser has filled; taking
  // it earlier would latch the synchroniser's reset value, not the pin.
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic       strap_sel_q, strap_sel_d;
  always_comb begin
    strap_cnt_d = strap_cnt_q;
    strap_sel_d = strap_sel_q;
    if (strap_cnt_q != 2'h3) begin
      strap_cnt_d = strap_cnt_q + 2'h1;
    end
    if (strap_cnt_q == 2'h2) begin
      strap_sel_d = sel_s2_q;  // [RULE24]
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_cnt_q <= 2'h0;
      strap_sel_q <= 1'b0;
    end else begin
      strap_cnt_q <= strap_cnt_d;
      strap_sel_q <= strap_sel_d;
    end
  end

  logic [6:0] my_addr;
  assign my_addr = strap_sel_q ? touch_i2c_pkg::BUS_ADDR_HI
                               : touch_i2c_pkg::BUS_ADDR_LO;  // [RULE24]

  // Transfer state.
  touch_i2c_pkg::state_e st_q, st_d;
  touch_i2c_pkg::mem_req_s mem_q, mem_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d, txb_q, txb_d, hold_q, hold_d;
  logic [7:0]  wcrc_q, wcrc_d, wprev_q, wprev_d, rcrc_q, rcrc_d;
  logic [1:0]  wcnt_q, wcnt_d;
  logic [14:0] ptr_q, ptr_d, wptr_q, wptr_d;
  logic        rw_q, rw_d, oe_q, oe_d, pcrc_q, pcrc_d, hv_q, hv_d;
  logic        rel_q, rel_d, pop_q, pop_d, fault_q, fault_d;

  logic [14:0] msg_end, msg_last;
  logic [7:0]  wcrc_in, wcrc_out, rcrc_in, rcrc_out, tx_pick;
  logic        byte_in, ack_rise, have_msg;
  assign msg_end  = MSG_ADDR + MSG_LEN;
  assign msg_last = pcrc_q ? msg_end : msg_end - touch_i2c_pkg::PTR_STEP;
  assign have_msg = (i_msg_count != 8'h00);
  assign byte_in  = (st_q == touch_i2c_pkg::ST_WR) && scl_fall_c
                    && (bit_q == touch_i2c_pkg::BYTE_BITS);
  assign ack_rise = (st_q == touch_i2c_pkg::ST_RD_ACK) && scl_rise_c;
  // Write CRC over everything after the bus address byte; read CRC restarts at MSG_ADDR.
  assign wcrc_in  = (wcnt_q == touch_i2c_pkg::WCNT_LO) ? CRC_INIT : wcrc_q;
  assign rcrc_in  = (wptr_q == MSG_ADDR) ? CRC_INIT : rcrc_q;

  crc8_step #(.POLY(CRC_POLY)) u_wcrc (
    .i_crc  (wcrc_in),
    .i_byte (sh_q),
    .o_crc  (wcrc_out)
  );
  crc8_step #(.POLY(CRC_POLY)) u_rcrc (
    .i_crc  (rcrc_in),
    .i_byte (txb_q),
    .o_crc  (rcrc_out)
  );

  // Byte to send: message CRC slot, invalid id, or memory data.
  always_comb begin
    if (pcrc_q && wptr_q == msg_end) begin
      tx_pick = rcrc_q;  // [RULE9]
    end else if (wptr_q == MSG_ADDR && !have_msg) begin
      tx_pick = touch_i2c_pkg::INVALID_ID;  // [RULE18]
    end else begin
      tx_pick = i_mem_rdata;
    end
  end

  always_comb begin
    st_d = st_q; bit_d = bit_q; sh_d = sh_q; txb_d = txb_q;
    hold_d = hold_q; hv_d = hv_q; wcnt_d = wcnt_q; rw_d = rw_q;
    oe_d = oe_q; ptr_d = ptr_q; pcrc_d = pcrc_q; wptr_d = wptr_q;
    wcrc_d = wcrc_q; wprev_d = wprev_q; rcrc_d = rcrc_q; rel_d = rel_q;
    mem_d = mem_q;
    mem_d.we = 1'b0;
    pop_d = 1'b0;
    fault_d = 1'b0;
    if (start_c || stop_c) begin
      // The last byte held back is the CRC in checksum mode.
      if (hv_q) begin
        if (pcrc_q) begin
          fault_d = (hold_q != wprev_q);  // [RULE1] [RULE23]
        end else begin
          mem_d = '{we: 1'b1, addr: wptr_q, data: hold_q};
        end
      end
      hv_d   = 1'b0;
      wptr_d = ptr_q;  // [RULE5] [RULE13]
      oe_d   = 1'b0;
      bit_d  = 4'h0;
      wcnt_d = touch_i2c_pkg::WCNT_LO;
      if (stop_c) begin
        rel_d = 1'b0;  // [RULE17]
      end
      st_d = start_c ? touch_i2c_pkg::ST_ADDR : touch_i2c_pkg::ST_IDLE;
    end else begin
      case (st_q)
        touch_i2c_pkg::ST_ADDR, touch_i2c_pkg::ST_WR: begin
          if (scl_rise_c) begin
            sh_d  = {sh_q[6:0], sda_s2_q};
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall_c && bit_q == touch_i2c_pkg::BYTE_BITS) begin
            bit_d = 4'h0;
            oe_d  = 1'b1;
            st_d  = touch_i2c_pkg::ST_ACK;
            if (st_q == touch_i2c_pkg::ST_ADDR) begin
              if (sh_q[7:1] == my_addr) begin
                rw_d   = sh_q[0];
                wptr_d = ptr_q;
              end else begin
                oe_d = 1'b0;
                st_d = touch_i2c_pkg::ST_IDLE;
              end
            end else begin
              wprev_d = wcrc_in;
              wcrc_d  = wcrc_out;
              case (wcnt_q)
                touch_i2c_pkg::WCNT_LO: begin
                  ptr_d[7:0] = sh_q;
                  wcnt_d     = touch_i2c_pkg::WCNT_HI;
                end
                touch_i2c_pkg::WCNT_HI: begin
                  ptr_d[14:8] = sh_q[6:0];  // [RULE3]
                  pcrc_d      = sh_q[7];  // [RULE3]
                  wptr_d      = {sh_q[6:0], ptr_q[7:0]};
                  wcnt_d      = touch_i2c_pkg::WCNT_DATA;
                end
                default: begin
                  // Stored regardless of how the CRC turns out.
                  if (hv_q) begin
                    // [RULE2]
                    mem_d  = '{we: 1'b1, addr: wptr_q, data: hold_q};
                    wptr_d = wptr_q + touch_i2c_pkg::PTR_STEP;
                  end
                  hold_d = sh_q;
                  hv_d   = 1'b1;
                end
              endcase
            end
          end
        end
        touch_i2c_pkg::ST_ACK: begin
          if (scl_fall_c) begin
            bit_d = 4'h0;
            if (rw_q) begin
              txb_d = tx_pick;
              sh_d  = tx_pick;
              oe_d  = ~tx_pick[7];  // [RULE22]
              st_d  = touch_i2c_pkg::ST_RD;
            end else begin
              oe_d = 1'b0;
              st_d = touch_i2c_pkg::ST_WR;
            end
          end
        end
        touch_i2c_pkg::ST_RD: begin
          if (scl_fall_c) begin
            if (bit_q == touch_i2c_pkg::LAST_TX_BIT) begin
              oe_d = 1'b0;
              st_d = touch_i2c_pkg::ST_RD_ACK;
            end else begin
              sh_d  = {sh_q[6:0], 1'b0};
              oe_d  = ~sh_q[6];  // [RULE22]
              bit_d = bit_q + 4'h1;
            end
          end
        end
        touch_i2c_pkg::ST_RD_ACK: begin
          if (scl_rise_c) begin
            rcrc_d = rcrc_out;  // [RULE9]
            if (wptr_q == msg_last && have_msg) begin
              pop_d = 1'b1;
            end
            if (sda_s2_q) begin
              wptr_d = ptr_q;  // [RULE5] [RULE13]
              st_d   = touch_i2c_pkg::ST_IDLE;
            end else begin
              if (wptr_q == MSG_ADDR && have_msg
                  && (!i_comms_cfg.level_mode
                      || i_msg_count == 8'h01)) begin
                rel_d = 1'b1;  // [RULE16] [RULE19]
              end
              if (wptr_q == CNT_ADDR || wptr_q == msg_last) begin
                wptr_d = MSG_ADDR;  // [RULE7]
              end else begin
                wptr_d = wptr_q + touch_i2c_pkg::PTR_STEP;  // [RULE6]
              end
              st_d = touch_i2c_pkg::ST_ACK;
            end
          end
        end
        default: begin
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q    <= touch_i2c_pkg::ST_IDLE;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
      txb_q   <= 8'h00;
      hold_q  <= 8'h00;
      hv_q    <= 1'b0;
      wcnt_q  <= touch_i2c_pkg::WCNT_LO;
      rw_q    <= 1'b0;
      oe_q    <= 1'b0;
      ptr_q   <= touch_i2c_pkg::PTR_RST;
      pcrc_q  <= 1'b0;
      wptr_q  <= touch_i2c_pkg::PTR_RST;
      wcrc_q  <= 8'h00;
      wprev_q <= 8'h00;
      rcrc_q  <= 8'h00;
      rel_q   <= 1'b0;
      mem_q   <= '0;
      pop_q   <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      txb_q   <= txb_d;
      hold_q  <= hold_d;
      hv_q    <= hv_d;
      wcnt_q  <= wcnt_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
      ptr_q   <= ptr_d;
      pcrc_q  <= pcrc_d;
      wptr_q  <= wptr_d;
      wcrc_q  <= wcrc_d;
      wprev_q <= wprev_d;
      rcrc_q  <= rcrc_d;
      rel_q   <= rel_d;
      mem_q   <= mem_d;
      pop_q   <= pop_d;
      fault_q <= fault_d;
    end
  end

  // Pending line: forced by config, else messages waiting and not released.
  logic chg_low_q, chg_low_d;
  always_comb begin
    if (i_comms_cfg.force_en) begin
      chg_low_d = i_comms_cfg.force_low;  // [RULE21]
    end else begin
      chg_low_d = have_msg && !rel_q;  // [RULE14] [RULE16] [RULE17]
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chg_low_q <= 1'b0;
    end else begin
      chg_low_q <= chg_low_d;
    end
  end

  // No clock stretching, so SCL is never pulled.
  assign o_scl_o            = 1'b0;  // [RULE22]
  assign o_scl_oe           = 1'b0;
  assign o_sda_o            = 1'b0;
  assign o_sda_oe           = oe_q;
  assign o_msg_pending_n_o  = 1'b0;
  assign o_msg_pending_n_oe = chg_low_q;
  assign o_mem_raddr        = wptr_q;
  assign o_mem              = mem_q;
  assign o_msg_pop          = pop_q;
  assign o_comms_crc_fault  = fault_q;

  a_fault_cause: assert property (  // [RULE23]
    o_comms_crc_fault |-> $past(pcrc_q && hv_q && (start_c || stop_c)))
    else $error("crc fault without checksummed write end");
  a_store_bad_crc: assert property (  // [RULE2]
    (byte_in && wcnt_q == touch_i2c_pkg::WCNT_DATA && hv_q)
    |=> o_mem.we && o_mem.data == $past(hold_q))
    else $error("held data byte not stored");
  a_addr_strip: assert property (  // [RULE3]
    (byte_in && wcnt_q == touch_i2c_pkg::WCNT_HI)
    |=> wptr_q[14:8] == $past(sh_q[6:0]) && pcrc_q == $past(sh_q[7]))
    else $error("checksum bit not stripped from address");
  a_nack_restore: assert property (  // [RULE5]
    (ack_rise && sda_s2_q) |=> wptr_q == $past(ptr_q))
    else $error("pointer not restored on nack");
  a_ptr_advance: assert property (  // [RULE6]
    (ack_rise && !sda_s2_q && wptr_q != CNT_ADDR && wptr_q != msg_last)
    |=> wptr_q == $past(wptr_q) + touch_i2c_pkg::PTR_STEP)
    else $error("pointer did not advance");
  a_msg_reload: assert property (  // [RULE7]
    (ack_rise && !sda_s2_q && wptr_q == msg_last) |=> wptr_q == MSG_ADDR)
    else $error("pointer not reloaded to message object");
  a_stop_restore: assert property (  // [RULE13]
    stop_c |=> wptr_q == $past(ptr_q) ##1 st_q == touch_i2c_pkg::ST_IDLE)
    else $error("stop did not restore pointer");
  a_invalid_id: assert property (  // [RULE18]
    (st_q == touch_i2c_pkg::ST_ACK && scl_fall_c && rw_q
     && wptr_q == MSG_ADDR && !have_msg)
    |=> txb_q == touch_i2c_pkg::INVALID_ID)
    else $error("empty queue did not give id 255");
  a_chg_force: assert property (  // [RULE21]
    i_comms_cfg.force_en
    |=> o_msg_pending_n_oe == $past(i_comms_cfg.force_low))
    else $error("forced line state not applied");
  a_chg_assert: assert property (  // [RULE16]
    (!i_comms_cfg.force_en && have_msg && !rel_q) |=> o_msg_pending_n_oe)
    else $error("pending line not low with message waiting");
  a_level_hold: assert property (  // [RULE19]
    (ack_rise && !sda_s2_q && wptr_q == MSG_ADDR && !rel_q
     && i_comms_cfg.level_mode && i_msg_count > 8'h01) |=> !rel_q)
    else $error("level mode released before last message");

  c_crc_fault: cover property (o_comms_crc_fault);
  c_msg_pop:   cover property (o_msg_pop ##[1:1000] o_msg_pop);
  c_release:   cover property ($rose(rel_q) ##[1:1000] stop_c);
  c_wr_store:  cover property (o_mem.we && pcrc_q);

endmodule : touch_i2c_port

// ---- touch_i2c_pkg.sv ----
// Constants, types and layout shared by the touch host message port.
// How it works
// RULE1: Checksummed write ends with CRC over address+data.
// RULE2: Data is stored even when CRC mismatches.
// RULE3: Address top bit requests checksum; stripped off.
// RULE4: Host sets pointer by write, then reads.
// RULE5: Pointer restored to start on NACK/STOP.
// RULE6: Pointer advances after every byte read.
// RULE7: Message reads reload pointer to message object.
// RULE8: Host reads at least one byte per read.
// RULE9: Message read: report id, data, optional CRC.
// RULE10: Host requests per-message CRC via pointer top bit.
// RULE11: Host reads count byte, then count messages.
// RULE12: No START/STOP between messages in continuous read.
// RULE13: Final NACK/STOP returns pointer to count object.
// RULE14: Pending line is active-low open-drain message flag.
// RULE15: Host uses pending line, never polls.
// RULE16: Edge mode: release after first report id acked.
// RULE17: Edge mode: STOP re-asserts line if messages remain.
// RULE18: Report id 255 returned when no message remains.
// RULE19: Level mode: release after last report id acked.
// RULE20: Host samples pending line only between messages.
// RULE21: Config selects line mode and can force it.
// RULE22: SDA and SCL only driven low or released.
// RULE23: CRC mismatch on write raises comms fault.
// RULE24: Bus address 0x4A or 0x4B from strap pin.
// RULE25: CRC polynomial and start value are parameters.
package touch_i2c_pkg;

  localparam logic [6:0]  BUS_ADDR_LO  = 7'h4A;
  localparam logic [6:0]  BUS_ADDR_HI  = 7'h4B;
  localparam logic [7:0]  CRC_POLY_DEF = 8'h07;
  localparam logic [7:0]  CRC_INIT_DEF = 8'h00;
  localparam logic [7:0]  INVALID_ID   = 8'hFF;
  localparam logic [14:0] CNT_ADDR_DEF = 15'h00FF;
  localparam logic [14:0] MSG_ADDR_DEF = 15'h0100;
  localparam logic [14:0] MSG_LEN_DEF  = 15'h000A;
  localparam logic [14:0] PTR_RST      = 15'h0000;
  localparam logic [14:0] PTR_STEP     = 15'h0001;
  localparam logic [3:0]  BYTE_BITS    = 4'h8;
  localparam logic [3:0]  LAST_TX_BIT  = 4'h7;
  localparam logic [1:0]  WCNT_LO      = 2'h0;
  localparam logic [1:0]  WCNT_HI      = 2'h1;
  localparam logic [1:0]  WCNT_DATA    = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ADDR   = 3'h1,
    ST_ACK    = 3'h3,
    ST_WR     = 3'h2,
    ST_RD     = 3'h6,
    ST_RD_ACK = 3'h7
  } state_e;

  typedef struct packed {
    logic        we;
    logic [14:0] addr;
    logic [7:0]  data;
  } mem_req_s;

  typedef struct packed {
    logic force_en;
    logic force_low;
    logic level_mode;
  } chg_cfg_s;

endpackage : touch_i2c_pkg

// ---- crc8_step.sv ----
// One-byte step of a parameterised CRC-8, MSB first.
`timescale 1ns/1ps
module crc8_step #(
  parameter logic [7:0] POLY = touch_i2c_pkg::CRC_POLY_DEF
) (
  input  wire logic [7:0] i_crc,   // CRC before the byte
  input  wire logic [7:0] i_byte,  // Byte to fold in
  output logic      [7:0] o_crc    // CRC after the byte
);
  always_comb begin
    logic [7:0] c;
    c = i_crc ^ i_byte;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ POLY) : (c << 1);  // [RULE25]
    end
    o_crc = c;
  end
endmodule : crc8_step

// ---- touch_host_model.sv ----
// Host-side I2C controller model that drives SCL and SDA open-drain.
`timescale 1ns/1ps
module touch_host_model (
  input  wire logic i_scl,      // Resolved SCL level
  input  wire logic i_sda,      // Resolved SDA level
  output logic      o_scl_low,  // Pull SCL low
  output logic      o_sda_low   // Pull SDA low
);
  localparam int QTR = 20;  // Quarter of the 80 ns SCL period.

  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end

  // Also serves as a repeated start; SCL is left low afterwards.
  task automatic start();
    o_sda_low = 1'b0;
    #QTR o_scl_low = 1'b0;
    #QTR o_sda_low = 1'b1;
    #QTR o_scl_low = 1'b1;
    #QTR;
  endtask : start

  task automatic stop();
    o_sda_low = 1'b1;
    #QTR o_scl_low = 1'b0;
    #QTR o_sda_low = 1'b0;
    #(2 * QTR);
  endtask : stop

  // Data moves only while SCL is low, so it never fakes a start or stop.
  task automatic bit_x(input logic b, output logic r);
    o_sda_low = ~b;
    #QTR o_scl_low = 1'b0;
    #QTR r = i_sda;
    #QTR o_scl_low = 1'b1;
    #QTR;
  endtask : bit_x

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  // A read releases SDA for the data and acknowledges all but the last.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(last, r);
  endtask : rd_byte
endmodule : touch_host_model

// ---- touch_i2c_port_tb.sv ----
// Self-checking bench for the touch host message port.
`timescale 1ns/1ps
module touch_i2c_port_tb;
  localparam logic [14:0] CNT = touch_i2c_pkg::CNT_ADDR_DEF;
  localparam logic [14:0] MSG = touch_i2c_pkg::MSG_ADDR_DEF;
  localparam logic [7:0]  SLA = {touch_i2c_pkg::BUS_ADDR_LO, 1'b0};

  logic                     sys_clk = 1'b0;
  logic                     rst_n;
  logic                     addr_sel = 1'b0;
  logic                     scl_low;
  logic                     sda_low;
  wire logic                scl;
  wire logic                sda;
  touch_i2c_pkg::chg_cfg_s  cfg;
  logic [7:0]               msg_cnt;
  logic [7:0]               rdata;
  logic [14:0]              raddr;
  touch_i2c_pkg::mem_req_s  mem;
  touch_i2c_pkg::mem_req_s  wq[$];
  logic                     scl_o;
  logic                     scl_oe;
  logic                     sda_o;
  logic                     sda_oe;
  logic                     pend_o;
  logic                     pend_oe;
  logic                     pop;
  logic                     fault;
  logic [7:0]               n_fault = 8'h00;
  logic                     bad_drive = 1'b0;
  int                       fail_count = 0;
  int                       n_tests = 0;

  function automatic logic [7:0] mem_f(input logic [14:0] a);
    return a[7:0] + 8'h11;
  endfunction : mem_f

  function automatic logic [7:0] crc_f(input logic [7:0] c,
                                       input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ touch_i2c_pkg::CRC_POLY_DEF) : (x << 1);
    end
    return x;
  endfunction : crc_f

  // Both wires have pull-ups, so a released line reads high.
  assign scl   = ~(scl_low | scl_oe);
  assign sda   = ~(sda_low | sda_oe);
  assign rdata = (raddr == CNT) ? msg_cnt : mem_f(raddr);

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (mem.we === 1'b1) wq.push_back(mem);
    if (fault === 1'b1) n_fault <= n_fault + 8'h01;
    if (pop === 1'b1 && msg_cnt != 8'h00) msg_cnt <= msg_cnt - 8'h01;
    if (rst_n && {scl_o, scl_oe, sda_o, pend_o} !== 4'h0) bad_drive = 1'b1;
  end

  touch_host_model i_host (
    .i_scl     (scl),
    .i_sda     (sda),
    .o_scl_low (scl_low),
    .o_sda_low (sda_low)
  );

  touch_i2c_port i_dut (
    .i_sys_clk          (sys_clk),
    .i_rst_n            (rst_n),
    .i_scl              (scl),
    .i_sda              (sda),
    .i_addr_select_pin  (addr_sel),
    .i_comms_cfg        (cfg),
    .i_msg_count        (msg_cnt),
    .i_mem_rdata        (rdata),
    .o_scl_o            (scl_o),
    .o_scl_oe           (scl_oe),
    .o_sda_o            (sda_o),
    .o_sda_oe           (sda_oe),
    .o_msg_pending_n_o  (pend_o),
    .o_msg_pending_n_oe (pend_oe),
    .o_mem_raddr        (raddr),
    .o_mem              (mem),
    .o_msg_pop          (pop),
    .o_comms_crc_fault  (fault)
  );

  task automatic give_verdict();
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic set_in(input logic [7:0] c,
                        input touch_i2c_pkg::chg_cfg_s g);
    @(posedge sys_clk);
    #1;
    msg_cnt = c;
    cfg = g;
    repeat (4) @(posedge sys_clk);
  endtask : set_in

  task automatic wr_txn(input logic [7:0] b[$], input logic cs,
                        input logic bad);
    logic       ack;
    logic [7:0] c;
    c = touch_i2c_pkg::CRC_INIT_DEF;
    i_host.start();
    i_host.wr_byte(SLA, ack);
    chk({7'h0, ack}, 8'h01);
    foreach (b[i]) begin
      i_host.wr_byte(b[i], ack);
      chk({7'h0, ack}, 8'h01);
      c = crc_f(c, b[i]);
    end
    if (cs) i_host.wr_byte(c ^ {7'h0, bad}, ack);
    i_host.stop();
    repeat (3) @(posedge sys_clk);
  endtask : wr_txn

  task automatic chk_wr(input logic [14:0] a, input logic [7:0] d);
    touch_i2c_pkg::mem_req_s m;
    m = (wq.size() != 0) ? wq.pop_front() : '0;
    chk(m.data, d);
    chk({1'b0, m.addr[14:8]}, {1'b0, a[14:8]});
    chk(m.addr[7:0], a[7:0]);
  endtask : chk_wr

  task automatic rd_txn(input int n, output logic [7:0] r[$],
                        output logic p[$]);
    logic       ack;
    logic [7:0] d;
    r = {};
    p = {};
    i_host.start();
    i_host.wr_byte(SLA | 8'h01, ack);
    chk({7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      i_host.rd_byte(i == n - 1, d);
      r.push_back(d);
      p.push_back(pend_oe);
    end
    i_host.stop();
    repeat (4) @(posedge sys_clk);
  endtask : rd_txn

  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end

  initial begin
    logic [7:0] r[$];
    logic       p[$];
    logic       ack;
    logic [7:0] c;
    rst_n = 1'b0;
    cfg = '0;
    msg_cnt = 8'h00;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    i_host.start();
    i_host.wr_byte({touch_i2c_pkg::BUS_ADDR_HI, 1'b0}, ack);
    chk({7'h0, ack}, 8'h00);
    i_host.stop();
    wr_txn('{8'h34, 8'h02, 8'hA1, 8'hA2}, 1'b0, 1'b0);
    chk_wr(15'h0234, 8'hA1);
    chk_wr(15'h0235, 8'hA2);
    wr_txn('{8'h34, 8'h92, 8'h96}, 1'b1, 1'b0);
    chk_wr(15'h1234, 8'h96);
    chk(n_fault, 8'h00);
    wr_txn('{8'h34, 8'h92, 8'h96}, 1'b1, 1'b1);
    chk_wr(15'h1234, 8'h96);
    chk(n_fault, 8'h01);
    chk(8'(wq.size()), 8'h00);
    wr_txn('{8'h10, 8'h00}, 1'b0, 1'b0);
    rd_txn(3, r, p);
    for (int i = 0; i < 3; i++) begin
      chk(r[i], mem_f(15'h0010 + 15'(i)));
    end
    rd_txn(1, r, p);
    chk(r[0], mem_f(15'h0010));
    set_in(8'h02, '0);
    chk({7'h0, pend_oe}, 8'h01);
    wr_txn('{CNT[7:0], {1'b0, CNT[14:8]}}, 1'b0, 1'b0);
    rd_txn(11, r, p);
    chk(r[0], 8'h02);
    for (int i = 0; i < 10; i++) begin
      chk(r[1 + i], mem_f(MSG + 15'(i)));
    end
    chk({7'h0, p[2]}, 8'h00);
    chk({7'h0, pend_oe}, 8'h01);
    rd_txn(12, r, p);
    chk(r[1], mem_f(MSG));
    chk(r[11], touch_i2c_pkg::INVALID_ID);
    chk({7'h0, pend_oe}, 8'h00);
    rd_txn(1, r, p);
    chk(r[0], 8'h00);
    set_in(8'h02, touch_i2c_pkg::chg_cfg_s'(3'b001));
    rd_txn(21, r, p);
    chk({7'h0, p[2]}, 8'h01);
    chk({7'h0, p[10]}, 8'h01);
    chk({7'h0, p[12]}, 8'h00);
    set_in(8'h01, '0);
    wr_txn('{CNT[7:0], {1'b1, CNT[14:8]}}, 1'b1, 1'b0);
    rd_txn(12, r, p);
    c = touch_i2c_pkg::CRC_INIT_DEF;
    for (int i = 0; i < 10; i++) c = crc_f(c, mem_f(MSG + 15'(i)));
    chk(r[11], c);
    set_in(8'h00, touch_i2c_pkg::chg_cfg_s'(3'b110));
    chk({7'h0, pend_oe}, 8'h01);
    set_in(8'h01, touch_i2c_pkg::chg_cfg_s'(3'b100));
    chk({7'h0, pend_oe}, 8'h00);
    chk({7'h0, bad_drive}, 8'h00);
    // Second reset with the strap high: the upper bus address must answer.
    #1 addr_sel = 1'b1;
    rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    i_host.start();
    i_host.wr_byte({touch_i2c_pkg::BUS_ADDR_HI, 1'b0}, ack);
    chk({7'h0, ack}, 8'h01);
    i_host.stop();
    give_verdict();
  end
endmodule : touch_i2c_port_tb
